// File: src/sprid_regs.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Bit rate is clock over divisor times (1 + factor) for divisors of 2 or more
// - Mask bits 0-5 enable the six sources
// - Receive write while full flags overflow
// - Unread receive data past timeout flags timeout
// - Raw status shows conditions regardless of mask
// - Masked status is raw ANDed with mask
// - Clear bits 0,1,2 drop overflow, timeout, starve
// - DMA enables at bits 0 and 2
// - Sixteen-bit frames to receive field
// - Mask, masked status, DMA, prescaler reset to zero; raw status shows tx empty
// - Receive level trigger at one, four, eight
module sprid_regs
  import sprid_pkg::*;
#(
  parameter int AW          = 8,
  parameter int TIMEOUT_CYC = SPRID_RX_TIMEOUT_CYC,
  parameter int FIFO_DEPTH  = 16
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // AXI4-Lite slave
  input  wire logic [AW-1:0]         s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AW-1:0]         s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // FIFO state from the data path, same clock
  input  wire sprid_pkg::sprid_fifo_s fifo_i,
  input  wire logic                  tx_underrun_i,
  // Block outputs
  output logic                       irq_o,
  output logic                       bit_tick_o,
  output logic                       rx_dma_req_o,
  output logic                       tx_dma_req_o,
  output logic [15:0]                frames_to_receive_o
);

  import sprid_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]                 prescale_divisor_r;
  logic [5:0]                 irq_mask_r;
  logic [2:0]                 dma_ctrl_r;
  logic [15:0]                frames_r;
  logic [13:0]                port_ctrl_r;
  logic                       rx_overflow_raw_r;
  logic                       rx_timeout_raw_r;
  logic                       tx_starve_raw_r;
  logic [15:0]                timeout_cnt_r;
  logic [SPRID_IRQ_COUNT-1:0] raw_status;
  logic [SPRID_IRQ_COUNT-1:0] masked_status;
  logic                       rx_level_raw;
  logic                       tx_level_raw;
  logic                       tx_empty_raw;
  logic [2:0]                 rx_trigger_level_select;
  logic [2:0]                 tx_trigger_level_select;
  logic [7:0]                 serial_clock_rate_factor;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic [AW-1:0] aw_addr_r;
  logic          aw_held_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic          w_held_r;
  logic          wr_fire;
  logic          wr_hit;
  logic [7:0]    wr_ofs;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ofs        = 8'(aw_addr_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_comb
  begin
    unique case (wr_ofs)
      SPRID_OFS_PRESCALE, SPRID_OFS_IRQ_MASK, SPRID_OFS_IRQ_CLEAR,
      SPRID_OFS_DMA_CTRL, SPRID_OFS_RX_FRAMES, SPRID_OFS_PORT_CTRL:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SPRID_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? SPRID_RESP_OKAY : SPRID_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescale_divisor_r <= SPRID_RST_PRESCALE;
      irq_mask_r         <= SPRID_RST_IRQ_MASK;
      dma_ctrl_r         <= SPRID_RST_DMA_CTRL;
      frames_r           <= SPRID_RST_RX_FRAMES;
      port_ctrl_r        <= SPRID_RST_PORT_CTRL;
    end
    else if (wr_fire)
    begin
      // Divisor is stored as written; odd or out-of-range values are software's fault
      if (wr_ofs == SPRID_OFS_PRESCALE && w_strb_r[0])
        prescale_divisor_r <= w_data_r[7:0];
      if (wr_ofs == SPRID_OFS_IRQ_MASK && w_strb_r[0])
        irq_mask_r <= w_data_r[5:0];
      if (wr_ofs == SPRID_OFS_DMA_CTRL && w_strb_r[0])
        dma_ctrl_r <= {w_data_r[SPRID_DMA_TX_BIT], 1'b0, w_data_r[SPRID_DMA_RX_BIT]};
      if (wr_ofs == SPRID_OFS_RX_FRAMES)
      begin
        if (w_strb_r[0])
          frames_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1])
          frames_r[15:8] <= w_data_r[15:8];
      end
      if (wr_ofs == SPRID_OFS_PORT_CTRL)
      begin
        if (w_strb_r[0])
          port_ctrl_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1])
          port_ctrl_r[13:8] <= w_data_r[13:8];
      end
    end
  end

  assign serial_clock_rate_factor = port_ctrl_r[SPRID_PC_RATE_LSB +: 8];
  assign rx_trigger_level_select  = port_ctrl_r[SPRID_PC_RXSEL_LSB +: 3];
  assign tx_trigger_level_select  = port_ctrl_r[SPRID_PC_TXSEL_LSB +: 3];

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  logic clr_write;

  assign clr_write = wr_fire && wr_ofs == SPRID_OFS_IRQ_CLEAR && w_strb_r[0];

  function automatic logic level_hit(input logic [2:0] sel, input logic [4:0] cnt);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      SPRID_LVL_ONE:   hit = (cnt >= 5'd1);
      SPRID_LVL_FOUR:  hit = (cnt >= 5'd4);
      SPRID_LVL_EIGHT: hit = (cnt >= 5'd8);
      default:         hit = 1'b0; // Reserved codes never trigger
    endcase
    return hit;
  endfunction : level_hit

  // Level-type sources have no clear bit and simply follow the FIFO
  assign rx_level_raw = level_hit(rx_trigger_level_select, fifo_i.rx_count);
  assign tx_level_raw = level_hit(tx_trigger_level_select, fifo_i.tx_count);
  assign tx_empty_raw = (fifo_i.tx_count == 5'd0);

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_overflow_raw_r <= 1'b0;
    else if (fifo_i.rx_write && fifo_i.rx_count >= 5'(FIFO_DEPTH))
      rx_overflow_raw_r <= 1'b1;
    else if (clr_write && w_data_r[SPRID_CLR_RX_OVERFLOW])
      rx_overflow_raw_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_starve_raw_r <= 1'b0;
    else if (tx_underrun_i)
      tx_starve_raw_r <= 1'b1;
    else if (clr_write && w_data_r[SPRID_CLR_TX_STARVE])
      tx_starve_raw_r <= 1'b0;
  end

  // Timeout counter restarts on any read or when the FIFO empties
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timeout_cnt_r <= 16'h0000;
    else if (fifo_i.rx_count == 5'd0 || fifo_i.rx_read)
      timeout_cnt_r <= 16'h0000;
    else if (timeout_cnt_r < 16'(TIMEOUT_CYC))
      timeout_cnt_r <= timeout_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_timeout_raw_r <= 1'b0;
    else if (fifo_i.rx_count != 5'd0 && !fifo_i.rx_read && timeout_cnt_r == 16'(TIMEOUT_CYC - 1))
      rx_timeout_raw_r <= 1'b1;
    else if (clr_write && w_data_r[SPRID_CLR_RX_TIMEOUT])
      rx_timeout_raw_r <= 1'b0;
  end

  always_comb
  begin
    raw_status = '0;
    raw_status[SPRID_IRQ_RX_OVERFLOW] = rx_overflow_raw_r;
    raw_status[SPRID_IRQ_RX_TIMEOUT]  = rx_timeout_raw_r;
    raw_status[SPRID_IRQ_RX_LEVEL]    = rx_level_raw;
    raw_status[SPRID_IRQ_TX_LEVEL]    = tx_level_raw;
    raw_status[SPRID_IRQ_TX_STARVE]   = tx_starve_raw_r;
    raw_status[SPRID_IRQ_TX_EMPTY]    = tx_empty_raw;
  end

  assign masked_status = raw_status & irq_mask_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |masked_status;
  end

  // ****************************************************************
  // DMA requests
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_dma_req_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
    end
    else
    begin
      rx_dma_req_o <= dma_ctrl_r[SPRID_DMA_RX_BIT] && fifo_i.rx_count != 5'd0;
      tx_dma_req_o <= dma_ctrl_r[SPRID_DMA_TX_BIT] && fifo_i.tx_count < 5'(FIFO_DEPTH);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      frames_to_receive_o <= SPRID_RST_RX_FRAMES;
    else
      frames_to_receive_o <= frames_r;
  end

  sprid_bitclk u_bitclk (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .prescale_divisor_i         (prescale_divisor_r),
    .serial_clock_rate_factor_i (serial_clock_rate_factor),
    .bit_tick_o                 (bit_tick_o)
  );

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [31:0] rd_word;
  logic        rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (8'(s_axi_araddr))
      SPRID_OFS_PRESCALE:   rd_word[7:0]  = prescale_divisor_r;
      SPRID_OFS_IRQ_MASK:   rd_word[5:0]  = irq_mask_r;
      SPRID_OFS_IRQ_RAW:    rd_word[5:0]  = raw_status;
      SPRID_OFS_IRQ_MASKED: rd_word[5:0]  = masked_status;
      SPRID_OFS_IRQ_CLEAR:  rd_word       = 32'h0000_0000; // Write-only
      SPRID_OFS_DMA_CTRL:   rd_word[2:0]  = dma_ctrl_r;
      SPRID_OFS_RX_FRAMES:  rd_word[15:0] = frames_r;
      SPRID_OFS_PORT_CTRL:  rd_word[13:0] = port_ctrl_r;
      default:              rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= SPRID_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? SPRID_RESP_OKAY : SPRID_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : sprid_regs

`default_nettype wire

// File: src/sprid_pkg.sv
package sprid_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] SPRID_OFS_PRESCALE   = 8'h10;
  localparam logic [7:0] SPRID_OFS_IRQ_MASK   = 8'h14;
  localparam logic [7:0] SPRID_OFS_IRQ_RAW    = 8'h18;
  localparam logic [7:0] SPRID_OFS_IRQ_MASKED = 8'h1c;
  localparam logic [7:0] SPRID_OFS_IRQ_CLEAR  = 8'h20;
  localparam logic [7:0] SPRID_OFS_DMA_CTRL   = 8'h24;
  localparam logic [7:0] SPRID_OFS_RX_FRAMES  = 8'h28;
  localparam logic [7:0] SPRID_OFS_PORT_CTRL  = 8'h2c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SPRID_IRQ_RX_OVERFLOW = 0;
  localparam int SPRID_IRQ_RX_TIMEOUT  = 1;
  localparam int SPRID_IRQ_RX_LEVEL    = 2;
  localparam int SPRID_IRQ_TX_LEVEL    = 3;
  localparam int SPRID_IRQ_TX_STARVE   = 4;
  localparam int SPRID_IRQ_TX_EMPTY    = 5;
  localparam int SPRID_IRQ_COUNT       = 6;
  localparam int SPRID_CLR_RX_OVERFLOW = 0;
  localparam int SPRID_CLR_RX_TIMEOUT  = 1;
  localparam int SPRID_CLR_TX_STARVE   = 2;
  localparam int SPRID_DMA_RX_BIT      = 0;
  localparam int SPRID_DMA_TX_BIT      = 2;
  localparam int SPRID_PC_RATE_LSB     = 0;
  localparam int SPRID_PC_RXSEL_LSB    = 8;
  localparam int SPRID_PC_TXSEL_LSB    = 11;

  // ****************************************************************
  // Reset values and levels
  // ****************************************************************
  localparam logic [7:0]  SPRID_RST_PRESCALE  = 8'h00;
  localparam logic [5:0]  SPRID_RST_IRQ_MASK  = 6'h00;
  localparam logic [2:0]  SPRID_RST_DMA_CTRL  = 3'h0;
  localparam logic [15:0] SPRID_RST_RX_FRAMES = 16'h0000;
  localparam logic [13:0] SPRID_RST_PORT_CTRL = 14'h0000;
  localparam logic [2:0]  SPRID_LVL_ONE       = 3'h0;
  localparam logic [2:0]  SPRID_LVL_FOUR      = 3'h1;
  localparam logic [2:0]  SPRID_LVL_EIGHT     = 3'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SPRID_CLK_PERIOD_NS  = 10;
  localparam int SPRID_RX_TIMEOUT_NS  = 320;
  localparam int SPRID_RX_TIMEOUT_CYC = SPRID_RX_TIMEOUT_NS / SPRID_CLK_PERIOD_NS;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [4:0] rx_count;
    logic [4:0] tx_count;
    logic       rx_write;
    logic       rx_read;
    logic       tx_read;
  } sprid_fifo_s;

  typedef enum logic [1:0] {
    SPRID_RESP_OKAY   = 2'b00,
    SPRID_RESP_SLVERR = 2'b10
  } sprid_resp_e;

endpackage : sprid_pkg

// File: src/sprid_bitclk.sv
`timescale 1ns/1ps
`default_nettype none

// Bit clock enable: one pulse every divisor x (1 + rate factor) cycles for a divisor of 2 or more
module sprid_bitclk
  import sprid_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] prescale_divisor_i,
  input  wire logic [7:0] serial_clock_rate_factor_i,
  output logic            bit_tick_o
);

  logic [7:0] pre_cnt_r;
  logic [7:0] rate_cnt_r;
  logic       pre_wrap;

  // A divisor below 2 keeps the counter idle rather than running at full rate
  assign pre_wrap = (prescale_divisor_i >= 8'h02) && (pre_cnt_r >= prescale_divisor_i - 8'h01);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_cnt_r <= 8'h00;
    else if (prescale_divisor_i < 8'h02 || pre_wrap)
      pre_cnt_r <= 8'h00;
    else
      pre_cnt_r <= pre_cnt_r + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_cnt_r <= 8'h00;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      bit_tick_o <= 1'b0;
      if (pre_wrap)
      begin
        if (rate_cnt_r >= serial_clock_rate_factor_i)
        begin
          rate_cnt_r <= 8'h00;
          bit_tick_o <= 1'b1;
        end
        else
          rate_cnt_r <= rate_cnt_r + 8'h01;
      end
    end
  end

endmodule : sprid_bitclk

`default_nettype wire

// File: sim/sprid_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module sprid_fifo_model
  import sprid_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [4:0]            cmd_i,
  output var sprid_pkg::sprid_fifo_s fifo_o,
  output logic                       tx_underrun_o
);
  // ****************************************************************
  // Occupancy of the data path FIFOs
  // ****************************************************************
  logic wr_ok;
  assign wr_ok = fifo_o.rx_write && (fifo_o.rx_count < 5'h10);
  // The count moves a cycle after the write pulse, so the pulse is seen with the old level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fifo_o        <= '0;
      tx_underrun_o <= 1'b0;
    end
    else
    begin
      fifo_o.rx_write <= cmd_i[0];
      fifo_o.rx_read  <= cmd_i[1] && (fifo_o.rx_count != 5'h0);
      fifo_o.rx_count <= fifo_o.rx_count + {4'h0, wr_ok} - {4'h0, fifo_o.rx_read};
      fifo_o.tx_read  <= cmd_i[3] && (fifo_o.tx_count != 5'h0);
      fifo_o.tx_count <= fifo_o.tx_count + {4'h0, cmd_i[2]} - {4'h0, cmd_i[3] && (fifo_o.tx_count != 5'h0)};
      tx_underrun_o   <= cmd_i[4];
    end
  end
endmodule : sprid_fifo_model
`default_nettype wire

// File: sim/sprid_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sprid_regs_checker
  import sprid_pkg::*;
#(
  parameter int AW          = 8,
  parameter int TIMEOUT_CYC = 4,
  parameter int FIFO_DEPTH  = 16
)
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic [AW-1:0]          s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire sprid_pkg::sprid_fifo_s fifo_i,
  input wire logic                   irq_o,
  input wire logic                   bit_tick_o,
  input wire logic                   rx_dma_req_o,
  input wire logic                   tx_dma_req_o,
  input wire logic [15:0]            frames_to_receive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_clears_a: assert property (disable iff (1'b0) rst_i |=> !irq_o && !bit_tick_o && !rx_dma_req_o
    && !tx_dma_req_o && frames_to_receive_o == 16'h0 && s_axi_awready && s_axi_arready)
    else $error("outputs not cleared by reset");
  tick_single_a: assert property (bit_tick_o |=> !bit_tick_o)
    else $error("bit tick wider than one cycle");
  rx_dma_gate_a: assert property (rx_dma_req_o |-> $past(fifo_i.rx_count) != 5'h0)
    else $error("rx dma request with empty fifo");
  tx_dma_gate_a: assert property (tx_dma_req_o |-> $past(fifo_i.tx_count) < FIFO_DEPTH)
    else $error("tx dma request with full fifo");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40
    |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property (irq_o);
  cover property (bit_tick_o);
  cover property (tx_dma_req_o);
  cover property (rx_dma_req_o);
endmodule : sprid_regs_checker
bind sprid_regs sprid_regs_checker #(.AW(AW), .TIMEOUT_CYC(TIMEOUT_CYC), .FIFO_DEPTH(FIFO_DEPTH)) u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_awready(s_axi_awready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .fifo_i(fifo_i), .irq_o(irq_o),
  .bit_tick_o(bit_tick_o), .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o),
  .frames_to_receive_o(frames_to_receive_o));
`default_nettype wire

// File: sim/test_spi_prescaler_irq_dma_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_prescaler_irq_dma_regs;
  import sprid_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r; } sprid_row_s;
  logic        clk_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        irq, tick, rx_dma, tx_dma, underrun;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] frames;
  logic [4:0]  cmd;
  sprid_fifo_s fifo;
  sprid_row_s  rows [7];
  int          n_fail, check_count, cyc;
  int          tdiv [3] = '{2, 4, 254};
  int          trate [3] = '{1, 2, 0};

  sprid_regs #(.TIMEOUT_CYC(4), .FIFO_DEPTH(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fifo_i(fifo), .tx_underrun_i(underrun), .irq_o(irq),
    .bit_tick_o(tick), .rx_dma_req_o(rx_dma), .tx_dma_req_o(tx_dma), .frames_to_receive_o(frames));
  sprid_fifo_model u_far (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .fifo_o(fifo), .tx_underrun_o(underrun));

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Each access starts one edge in, so a strobe is never assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // Ready follows valid, so the slave must hold its answer for a cycle
    do
    begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    got  = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic push(input logic [4:0] c, input int k);
    repeat (k)
    begin
      @(posedge clk_i);
      cmd <= c;
      @(posedge clk_i);
      cmd <= 5'h0;
    end
  endtask : push
  task automatic tick_gap(input int e);
    int n;
    n = 1;
    do @(posedge clk_i); while (tick !== 1'b1);
    @(posedge clk_i);
    while (tick !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("tick_gap", e, n);
  endtask : tick_gap
  task automatic summarize;
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    {rst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, cmd} = '0;
    wstrb = 4'hf;
    rows = '{'{8'h10, 32'hfe, 32'hfe, 2'b00}, '{8'h14, 32'h3f, 32'h3f, 2'b00}, '{8'h24, 32'h5, 32'h5, 2'b00},
             '{8'h28, 32'hbeef, 32'hbeef, 2'b00}, '{8'h20, 32'h7, 32'h0, 2'b00},
             '{8'h2c, 32'h901, 32'h901, 2'b00}, '{8'h40, 32'h0, 32'h0, 2'b10}};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Raw status shows tx empty after reset, the rest stays clear
    for (int a = 16; a <= 40; a += 4)
    begin
      rd(a[7:0]);
      chk("reset_reg", (a == 24) ? 32'h20 : 32'h0, got);
    end
    chk("irq", 32'h0, {31'h0, irq});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", {30'h0, rows[i].r}, {30'h0, resp});
      rd(rows[i].a);
      chk("rdata", rows[i].e, got);
      chk("rresp", {30'h0, rows[i].r}, {30'h0, resp});
    end
    chk("frames", 32'hbeef, {16'h0, frames});
    chk("irq", 32'h1, {31'h0, irq});
    // ****************************************************************
    // Sticky events, masking and clearing
    // ****************************************************************
    wr(8'h14, 32'h0);
    wr(8'h2c, 32'h0);
    push(5'h01, 17);
    push(5'h10, 1);
    rd(8'h18);
    chk("raw", 32'h37, got);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h14, 32'h1 << i);
      rd(8'h1c);
      chk("masked", 32'h37 & (32'h1 << i), got);
      chk("irq", (32'h37 >> i) & 32'h1, {31'h0, irq});
    end
    push(5'h02, 16);
    rd(8'h18);
    chk("raw", 32'h33, got);
    wr(8'h20, 32'h7);
    rd(8'h18);
    chk("raw", 32'h20, got);
    push(5'h04, 1);
    rd(8'h18);
    chk("raw", 32'h08, got);
    push(5'h08, 1);
    rd(8'h18);
    chk("raw", 32'h20, got);
    // ****************************************************************
    // Receive trigger levels at depths of four and eight, then DMA gating and bit tick spacing
    // ****************************************************************
    push(5'h01, 4);
    for (int s = 0; s < 3; s++)
    begin
      wr(8'h2c, s << 8);
      rd(8'h18);
      chk("rx_level", (s < 2) ? 32'h4 : 32'h0, got & 32'h4);
    end
    push(5'h01, 4);
    rd(8'h18);
    chk("rx_level8", 32'h4, got & 32'h4);
    wr(8'h24, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("dma", 32'h2, {30'h0, rx_dma, tx_dma});
    wr(8'h24, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("dma", 32'h1, {30'h0, rx_dma, tx_dma});
    foreach (tdiv[i])
    begin
      wr(8'h10, tdiv[i]);
      wr(8'h2c, trate[i]);
      tick_gap(tdiv[i] * (1 + trate[i]));
    end
    // ****************************************************************
    // Reset in mid-run
    // ****************************************************************
    wr(8'h14, 32'h3f);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h14);
    chk("mask", 32'h0, got);
    rd(8'h24);
    chk("dma_ctrl", 32'h0, got);
    rd(8'h10);
    chk("prescale", 32'h0, got);
    chk("outs", 32'h0, {frames, 13'h0, irq, rx_dma, tx_dma});
    summarize();
  end
endmodule : test_spi_prescaler_irq_dma_regs
`default_nettype wire
